// ==== hdl/tcbp_pkg.sv ====
// constants, types and helpers of the transmit buffer command parser
package tcbp_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_PKT = 4'h8;
  // status register fields
  localparam int STAT_ERR = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ST_LO = 2;
  localparam int STAT_BUSY = 4;
  // command word one fields
  localparam int A_IOC = 31;
  localparam int A_ALIGN_LO = 24;
  localparam int A_OFF_LO = 16;
  localparam int A_FIRST = 13;
  localparam int A_LAST = 12;
  // command word two fields
  localparam int B_TAG_LO = 16;
  localparam int B_CRC_DIS = 13;
  localparam int B_PAD_DIS = 12;
  // alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSV = 2'h3;
  // reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [11:0] SUM_RST = 12'h000;

  typedef enum logic [1:0] {
    TCBP_CMD_A = 2'h0,
    TCBP_CMD_B = 2'h1,
    TCBP_BODY = 2'h3
  } tcbp_state_e;

  typedef struct packed {
    logic irq_done;
    logic [1:0] align;
    logic [4:0] offset;
    logic first_seg_flag;
    logic last_seg_flag;
    logic [10:0] size;
  } tcbp_cmd_a_s;

  typedef struct packed {
    logic [15:0] tag;
    logic crc_add;
    logic pad_en;
    logic [10:0] len;
  } tcbp_pkt_s;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic sop;
    logic eop;
  } tcbp_mac_s;

  // lanes first .. first+cnt-1 set
  function automatic logic [3:0] lane_mask(input logic [1:0] first, input logic [2:0] cnt);
    logic [7:0] t;
    t = ((8'h01 << cnt) - 8'h01) << first;
    return t[3:0];
  endfunction
endpackage

// ==== hdl/tcbp_cmd_decode.sv ====
// field split and word counts of a transmit command pair
`timescale 1ns/10ps
module tcbp_cmd_decode
  import tcbp_pkg::*;
(
  // raw word
  input wire logic [31:0] word,
  // decoded fields
  output tcbp_pkg::tcbp_cmd_a_s cmd_a,
  output tcbp_pkg::tcbp_pkt_s pkt,
  // word counts of the buffer body
  output logic [2:0] skip_words,
  output logic [9:0] data_words,
  output logic [9:0] total_words
);
  logic [12:0] span;
  logic [12:0] amask;
  logic [12:0] dsum;
  logic [12:0] rnd;

  always_comb begin
    cmd_a.irq_done = word[A_IOC];
    cmd_a.align = word[A_ALIGN_LO+1:A_ALIGN_LO];
    cmd_a.offset = word[A_OFF_LO+4:A_OFF_LO];
    cmd_a.first_seg_flag = word[A_FIRST];
    cmd_a.last_seg_flag = word[A_LAST];
    cmd_a.size = word[10:0];
    pkt.tag = word[B_TAG_LO+15:B_TAG_LO];
    pkt.crc_add = !word[B_CRC_DIS] || word[B_PAD_DIS];
    pkt.pad_en = !word[B_PAD_DIS];
    pkt.len = word[10:0];
    skip_words = cmd_a.offset[4:2];
    dsum = {11'h000, cmd_a.offset[1:0]} + {2'h0, cmd_a.size} + 13'h0003;
    data_words = dsum[11:2];
    // body spans offset plus data, rounded up to the alignment
    case (cmd_a.align)
      ALIGN_16: amask = 13'h000F;
      ALIGN_32: amask = 13'h001F;
      default: amask = 13'h0003;
    endcase
    span = {8'h00, cmd_a.offset} + {2'h0, cmd_a.size};
    rnd = (span + amask) & ~amask;
    total_words = rnd[11:2];
  end
endmodule

// ==== hdl/tcbp_byte_ser.sv ====
// one-word holding stage that hands valid bytes to the transmit path
`timescale 1ns/10ps
module tcbp_byte_ser
  import tcbp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // word side
  input wire logic load,
  input wire logic [31:0] word,
  input wire logic [3:0] mask,
  input wire logic sop,
  input wire logic eop,
  output logic ready,
  // transmit path side
  input wire logic mac_ready,
  output tcbp_pkg::tcbp_mac_s mac
);
  logic [31:0] word_q, word_d;
  logic [3:0] mask_q, mask_d;
  logic sop_q, sop_d, eop_q, eop_d;
  tcbp_mac_s mac_q, mac_d;
  logic [1:0] lane;
  logic [1:0] last_lane_q, last_lane_d;
  logic take;
  logic [3:0] rest;

  assign ready = (mask_q == 4'h0);
  assign mac = mac_q;

  always_comb begin
    word_d = word_q;
    mask_d = mask_q;
    sop_d = sop_q;
    eop_d = eop_q;
    mac_d = mac_q;
    last_lane_d = last_lane_q;
    lane = 2'h3;
    // lowest pending lane goes first
    for (int i = 3; i >= 0; i--) begin
      if (mask_q[i]) begin
        lane = i[1:0];
      end
    end
    rest = mask_q & ~(4'h1 << lane);
    take = (mask_q != 4'h0) && (!mac_q.valid || mac_ready);
    if (!mac_q.valid || mac_ready) begin
      mac_d.valid = 1'b0;
      mac_d.sop = 1'b0;
      mac_d.eop = 1'b0;
    end
    if (take) begin
      mac_d.data = word_q[8*lane +: 8];
      mac_d.valid = 1'b1;
      mac_d.sop = sop_q;
      mac_d.eop = eop_q && (rest == 4'h0);
      mask_d = rest;
      sop_d = 1'b0;
      last_lane_d = lane;
    end
    if (load && ready) begin
      word_d = word;
      mask_d = mask;
      sop_d = sop;
      eop_d = eop;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= 32'h0000_0000;
      mask_q <= 4'h0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      mac_q <= '0;
      last_lane_q <= 2'h0;
    end else begin
      word_q <= word_d;
      mask_q <= mask_d;
      sop_q <= sop_d;
      eop_q <= eop_d;
      mac_q <= mac_d;
      last_lane_q <= last_lane_d;
    end
  end

  // within one word every byte comes from a higher lane than the one before
  a_lane_ascend: assert property (@(posedge clk) disable iff (!rst_n)
    (take && (mask_q != mask_d) && !$past(load && ready) && $past(take)) |-> (lane > last_lane_q))
    else $error("byte lanes left in descending order");
endmodule

// ==== hdl/tcbp_tx_parser.sv ====
// transmit buffer command parser with avalon register port
`timescale 1ns/10ps
module tcbp_tx_parser
  import tcbp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // transmit path
  input wire logic mac_ready,
  output tcbp_pkg::tcbp_mac_s mac_tx_path,
  output tcbp_pkg::tcbp_pkt_s mac_pkt,
  // flags
  output logic tx_error_flag,
  output logic tx_buffer_done_flag
);
  tcbp_state_e state_q, state_d;
  tcbp_cmd_a_s bufa_q, bufa_d;
  tcbp_pkt_s pkt_q, pkt_d;
  logic [2:0] skip_q, skip_d;
  logic [9:0] dw_q, dw_d;
  logic [9:0] tot_q, tot_d;
  logic [9:0] w_q, w_d;
  logic [10:0] rem_q, rem_d;
  logic first_q, first_d;
  logic [11:0] sum_q, sum_d;
  logic err_q, err_d;
  logic done_q, done_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;

  tcbp_cmd_a_s dec_a;
  tcbp_pkt_s dec_pkt;
  logic [2:0] dec_skip;
  logic [9:0] dec_dw;
  logic [9:0] dec_tot;

  logic ser_load;
  logic [3:0] ser_mask;
  logic ser_sop;
  logic ser_eop;
  logic ser_ready;

  logic req;
  logic acc;
  logic acc_wr;
  logic in_data;
  logic can_take;
  logic end_buf;
  logic [1:0] lane0;
  logic [2:0] room;
  logic [2:0] cnt;

  tcbp_cmd_decode u_dec (
    .word(writedata),
    .cmd_a(dec_a),
    .pkt(dec_pkt),
    .skip_words(dec_skip),
    .data_words(dec_dw),
    .total_words(dec_tot)
  );

  tcbp_byte_ser u_ser (
    .clk(clk),
    .rst_n(rst_n),
    .load(ser_load),
    .word(writedata),
    .mask(ser_mask),
    .sop(ser_sop),
    .eop(ser_eop),
    .ready(ser_ready),
    .mac_ready(mac_ready),
    .mac(mac_tx_path)
  );

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign mac_pkt = pkt_q;
  assign tx_error_flag = err_q;
  assign tx_buffer_done_flag = done_q;

  // bus handshake: waitrequest idles high and drops for the one edge that completes
  assign req = read || write;
  assign acc = req && !wait_q;
  assign acc_wr = acc && write && (address == ADDR_DATA);
  // leading skip words sit before the data, filler words after it
  assign in_data = (w_q >= {7'h00, skip_q}) && (w_q < ({7'h00, skip_q} + dw_q));
  assign lane0 = first_q ? bufa_q.offset[1:0] : 2'h0;
  assign room = 3'h4 - {1'b0, lane0};
  assign cnt = (rem_q < {8'h00, room}) ? rem_q[2:0] : room;

  always_comb begin
    can_take = 1'b1;
    if (write && (address == ADDR_DATA) && (state_q == TCBP_BODY) && in_data && !ser_ready) begin
      can_take = 1'b0;
    end
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q && can_take) begin
      wait_d = 1'b0;
      rdata_d = RDATA_RST;
      if (read) begin
        case (address)
          ADDR_STAT: begin
            rdata_d[STAT_ERR] = err_q;
            rdata_d[STAT_DONE] = done_q;
            rdata_d[STAT_ST_LO +: 2] = state_q;
            rdata_d[STAT_BUSY] = !ser_ready;
          end
          ADDR_PKT: begin
            rdata_d[B_TAG_LO +: 16] = pkt_q.tag;
            rdata_d[B_CRC_DIS] = pkt_q.crc_add;
            rdata_d[B_PAD_DIS] = pkt_q.pad_en;
            rdata_d[10:0] = pkt_q.len;
          end
          default: rdata_d = RDATA_RST;
        endcase
      end
    end
  end

  always_comb begin
    state_d = state_q;
    bufa_d = bufa_q;
    pkt_d = pkt_q;
    skip_d = skip_q;
    dw_d = dw_q;
    tot_d = tot_q;
    w_d = w_q;
    rem_d = rem_q;
    first_d = first_q;
    sum_d = sum_q;
    err_d = err_q;
    done_d = done_q;
    ser_load = 1'b0;
    ser_mask = 4'h0;
    ser_sop = 1'b0;
    ser_eop = 1'b0;
    end_buf = 1'b0;
    // write-one-to-clear; a set in the same cycle overrides below
    if (acc && write && (address == ADDR_STAT) && byteenable[0]) begin
      if (writedata[STAT_ERR]) begin
        err_d = 1'b0;
      end
      if (writedata[STAT_DONE]) begin
        done_d = 1'b0;
      end
    end
    if (acc_wr) begin
      case (state_q)
        TCBP_CMD_A: begin
          bufa_d = dec_a;
          skip_d = dec_skip;
          dw_d = dec_dw;
          tot_d = dec_tot;
          rem_d = dec_a.size;
          first_d = 1'b1;
          // a first segment restarts the running byte count
          sum_d = (dec_a.first_seg_flag ? SUM_RST : sum_q) + {1'b0, dec_a.size};
          state_d = TCBP_CMD_B;
        end
        TCBP_CMD_B: begin
          if (bufa_q.first_seg_flag) begin
            pkt_d = dec_pkt;
          end
          w_d = 10'h000;
          if (tot_q == 10'h000) begin
            end_buf = 1'b1;
          end else begin
            state_d = TCBP_BODY;
          end
        end
        TCBP_BODY: begin
          if (in_data && (rem_q != 11'h000)) begin
            ser_load = 1'b1;
            ser_mask = lane_mask(lane0, cnt);
            ser_sop = first_q && bufa_q.first_seg_flag;
            rem_d = rem_q - {8'h00, cnt};
            ser_eop = bufa_q.last_seg_flag && (rem_d == 11'h000);
            first_d = 1'b0;
          end
          w_d = w_q + 10'h001;
          if (w_q == (tot_q - 10'h001)) begin
            end_buf = 1'b1;
          end
        end
        default: state_d = TCBP_CMD_A;
      endcase
    end
    if (end_buf) begin
      state_d = TCBP_CMD_A;
      if (bufa_q.irq_done) begin
        done_d = 1'b1;
      end
      // length check against the declared packet length at the last segment
      if (bufa_q.last_seg_flag && (sum_q != {1'b0, pkt_d.len})) begin
        err_d = 1'b1;
      end
      if (bufa_q.align == ALIGN_RSV) begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TCBP_CMD_A;
      bufa_q <= '0;
      pkt_q <= '0;
      skip_q <= 3'h0;
      dw_q <= 10'h000;
      tot_q <= 10'h000;
      w_q <= 10'h000;
      rem_q <= 11'h000;
      first_q <= 1'b0;
      sum_q <= SUM_RST;
      err_q <= 1'b0;
      done_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= RDATA_RST;
    end else begin
      state_q <= state_d;
      bufa_q <= bufa_d;
      pkt_q <= pkt_d;
      skip_q <= skip_d;
      dw_q <= dw_d;
      tot_q <= tot_d;
      w_q <= w_d;
      rem_q <= rem_d;
      first_q <= first_d;
      sum_q <= sum_d;
      err_q <= err_d;
      done_q <= done_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take_a;
    acc_wr && (state_q == TCBP_CMD_A);
  endsequence
  sequence s_take_b;
    acc_wr && (state_q == TCBP_CMD_B);
  endsequence

  a_first_sum_restart: assert property (s_take_a ##0 writedata[A_FIRST] |=>
    (sum_q == {1'b0, $past(writedata[10:0])}))
    else $error("first segment did not restart byte count");
  a_size_latched: assert property (s_take_a |=>
    (bufa_q.size == $past(writedata[10:0])) && (state_q == TCBP_CMD_B))
    else $error("buffer size not latched or second word skipped");
  a_len_mismatch_err: assert property ((end_buf && bufa_q.last_seg_flag &&
    (sum_q != {1'b0, pkt_d.len})) |=> err_q)
    else $error("length mismatch did not raise error flag");
  a_tag_len_copy: assert property (s_take_b ##0 bufa_q.first_seg_flag |=>
    (pkt_q.tag == $past(writedata[31:16])) && (pkt_q.len == $past(writedata[10:0])))
    else $error("tag or packet length not copied");
  a_crc_suppress: assert property (s_take_b ##0 (bufa_q.first_seg_flag &&
    writedata[B_CRC_DIS] && !writedata[B_PAD_DIS]) |=> !pkt_q.crc_add)
    else $error("check sequence not suppressed");
  a_nopad_crc_on: assert property (s_take_b ##0 (bufa_q.first_seg_flag && writedata[B_PAD_DIS])
    |=> (pkt_q.crc_add && !pkt_q.pad_en))
    else $error("pad disable did not force check sequence");
  a_second_word_kept: assert property (s_take_b ##0 !bufa_q.first_seg_flag |=> $stable(pkt_q))
    else $error("second word kept for a non-first segment");
  a_filler_dropped: assert property ((acc_wr && (state_q == TCBP_BODY) && !in_data) |-> !ser_load)
    else $error("skip or filler word forwarded");
  a_first_lane_pick: assert property ((ser_load && first_q) |->
    ser_mask[bufa_q.offset[1:0]] && ((ser_mask & ((4'h1 << bufa_q.offset[1:0]) - 4'h1)) == 4'h0))
    else $error("first valid lane does not match offset");
  a_done_on_ioc: assert property ((end_buf && bufa_q.irq_done) |=> done_q ##1 (done_q || $past(acc)))
    else $error("done flag missing after loaded buffer");
endmodule

// ==== bench/tcbp_host_model.sv ====
// host cpu model: avalon master writing transmit command pairs and buffer words
`timescale 1ns/10ps
module tcbp_host_model (
  // clock
  input wire logic clk,
  // avalon-mm master
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // set when an access never got its answer
  output logic hung
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
    hung = 1'b0;
  end

  // request held until waitrequest is sampled low; no cycle count is assumed
  task automatic access(input logic rd, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be,
                        output logic [31:0] rdat);
    int n = 0;
    @(posedge clk);
    address <= adr;
    read <= rd;
    write <= !rd;
    byteenable <= be;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 2000);
    if (n >= 2000)
      hung = 1'b1;
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released data lines do not keep the old value
    writedata <= ~wd;
  endtask

  // command pair, skipped words, payload counting up from seed, filler up to the end alignment
  task automatic send_buf(input logic [31:0] cmd_a, input logic [31:0] cmd_b, input logic [7:0] seed);
    int off;
    int sz;
    int al;
    int tot;
    logic [31:0] w;
    logic [31:0] dummy;
    off = int'(cmd_a[20:16]);
    sz = int'(cmd_a[10:0]);
    al = (cmd_a[25:24] == 2'h1) ? 16 : (cmd_a[25:24] == 2'h2) ? 32 : 4;
    tot = (off + sz + al - 1) / al * al;
    access(1'b0, 4'h0, cmd_a & 32'h831F_37FF, 4'hF, dummy);
    // word two always goes out, even for middle buffers
    access(1'b0, 4'h0, cmd_b & 32'hFFFF_37FF, 4'hF, dummy);
    for (int p = 0; p < tot; p += 4) begin
      for (int k = 0; k < 4; k++)
        w[8*k +: 8] = (p + k >= off && p + k < off + sz) ? seed + 8'(p + k - off) : 8'hC3 ^ 8'(p + k);
      access(1'b0, 4'h0, w, 4'hF, dummy);
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench of the transmit buffer command parser
`timescale 1ns/10ps
module testbench;
  import tcbp_pkg::*;
  logic clk;
  logic rst_n;
  logic [3:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic mac_ready;
  tcbp_mac_s mac_tx_path;
  tcbp_pkt_s mac_pkt;
  logic tx_error_flag;
  logic tx_buffer_done_flag;
  logic hung;
  logic stall;
  logic [1:0] cyc;
  logic [31:0] s;
  logic [1:0] jj;
  logic [9:0] got_q[$];
  logic [9:0] exp_q[$];
  int mismatches;
  int cmp_count;
  int offs[4] = '{31, 0, 5, 18};
  int szs[4] = '{5, 1, 12, 33};

  tcbp_tx_parser dut_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .mac_ready(mac_ready), .mac_tx_path(mac_tx_path), .mac_pkt(mac_pkt), .tx_error_flag(tx_error_flag),
    .tx_buffer_done_flag(tx_buffer_done_flag));
  tcbp_host_model host_u (.clk(clk), .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .hung(hung));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // transmit path sink; stall mode takes a byte only one cycle in four
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    mac_ready <= !stall || cyc == 2'h0;
    if (rst_n && mac_tx_path.valid && mac_ready)
      got_q.push_back({mac_tx_path.data, mac_tx_path.sop, mac_tx_path.eop});
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    host_u.access(1'b1, a, 32'h0000_0000, 4'h0, d);
  endtask

  task automatic expect_bytes(input int sz, input logic [7:0] seed, input logic first, input logic last);
    for (int i = 0; i < sz; i++)
      exp_q.push_back({seed + 8'(i), first && i == 0, last && i == sz - 1});
  endtask

  // waits for the byte stage and the output byte to drain, then compares the byte stream
  task automatic check_stream();
    logic [31:0] st;
    int n = 0;
    do begin
      rd(ADDR_STAT, st);
      n++;
    end while ((st[STAT_BUSY] !== 1'b0 || mac_tx_path.valid !== 1'b0) && n < 500);
    if (n >= 500)
      mismatches++;
    chk(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk(32'(got_q[i]), 32'(exp_q[i]));
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic chk_flags(input logic [1:0] e);
    logic [31:0] st;
    @(negedge clk);
    chk({30'h0, tx_buffer_done_flag, tx_error_flag}, {30'h0, e});
    rd(ADDR_STAT, st);
    chk(st, {30'h0, e});
  endtask

  task automatic chk_pkt(input logic [31:0] e);
    logic [31:0] st;
    chk({mac_pkt.tag, 2'h0, mac_pkt.crc_add, mac_pkt.pad_en, 1'b0, mac_pkt.len}, e);
    rd(ADDR_PKT, st);
    chk(st, e);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    fork
      repeat (60000) @(posedge clk);
      wait (hung === 1'b1);
    join_any
    mismatches++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    mac_ready = 1'b0;
    stall = 1'b0;
    cyc = 2'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({readdata[30:0], waitrequest}, {RDATA_RST[30:0], 1'b1});
    chk_flags(2'h0);
    chk_pkt(32'h0000_0000);
    // three-buffer packet, slow sink; later word two tags must be ignored
    stall <= 1'b1;
    expect_bytes(79, 8'h10, 1'b1, 1'b0);
    expect_bytes(15, 8'h70, 1'b0, 1'b0);
    expect_bytes(17, 8'hA0, 1'b0, 1'b1);
    host_u.send_buf(32'h0107_204F, 32'h5A3C_006F, 8'h10);
    host_u.send_buf(32'h0100_000F, 32'h1111_006F, 8'h70);
    chk({31'h0, tx_buffer_done_flag}, 32'h0);
    host_u.send_buf(32'h810A_1011, 32'h2222_006F, 8'hA0);
    check_stream();
    chk_flags(2'h2);
    chk_pkt(32'h5A3C_306F);
    stall <= 1'b0;
    // every lane, alignment and check-sequence/pad combination
    for (int j = 0; j < 4; j++) begin
      jj = 2'(j);
      host_u.send_buf({8'(j % 3), 3'h0, 5'(offs[j]), 2'h0, 2'h3, 1'b0, 11'(szs[j])},
        {16'h0100 + 16'(j), 2'h0, jj, 1'b0, 11'(szs[j])}, 8'(40 * j));
      expect_bytes(szs[j], 8'(40 * j), 1'b1, 1'b1);
      check_stream();
      chk_pkt({16'h0100 + 16'(j), 2'h0, !jj[1] || jj[0], !jj[0], 1'b0, 11'(szs[j])});
      chk({31'h0, tx_error_flag}, 32'h0);
    end
    // length mismatch raises the error flag; both flags clear on write
    host_u.send_buf(32'h0000_3006, 32'h7777_0007, 8'h55);
    expect_bytes(6, 8'h55, 1'b1, 1'b1);
    check_stream();
    chk_flags(2'h3);
    host_u.access(1'b0, ADDR_STAT, 32'h0000_0003, 4'h1, s);
    chk_flags(2'h0);
    // reserved alignment code strips like four-byte alignment but flags an error
    host_u.send_buf(32'h0300_3002, 32'h4444_0002, 8'h66);
    expect_bytes(2, 8'h66, 1'b1, 1'b1);
    check_stream();
    chk_flags(2'h1);
    chk_pkt(32'h4444_3002);
    host_u.access(1'b0, ADDR_STAT, 32'h0000_0001, 4'h1, s);
    // unmapped and data reads answer zero; unmapped write changes nothing
    rd(4'hC, s);
    chk(s, 32'h0000_0000);
    rd(ADDR_DATA, s);
    chk(s, 32'h0000_0000);
    host_u.access(1'b0, 4'hC, 32'hFFFF_FFFF, 4'hF, s);
    chk_flags(2'h0);
    complete_run();
  end
endmodule
